// ==== range_solenoid_sequencer.v ====
// range solenoid sequencer: range decode, timed latch-in, power fail recycle
`timescale 1ns/10ps
`default_nettype none
`include "range_seq_defs.vh"

module range_solenoid_sequencer #(
	parameter integer TICK_CYCLES = `RSEQ_TICK_CYCLES, // 0.3 s step clock
	parameter integer HOLD_CYCLES = `RSEQ_HOLD_CYCLES  // 0.5 s second group
) (
	input  wire        clk_sys_i,
	input  wire        reset_n_i,
	input  wire        auto_mode_i,
	input  wire [3:0]  manual_range_i,
	input  wire [7:0]  thermo_range_i,
	input  wire        auto_recycle_n_i,
	input  wire        aux_supplies_good_in_i,
	input  wire        control_supply_trip_in_i,
	input  wire        sequence_option_links_i,
	output wire [10:0] coil_hold_o,
	output wire [10:0] coil_energize_o,
	output wire        screen_supply_off_o,
	output wire        selecting_o,
	output wire [3:0]  active_range_o
);

	// sequencer states
	localparam [1:0] ST_IDLE = 2'h0; // range settled
	localparam [1:0] ST_RUN  = 2'h1; // selection pass under way
	localparam [1:0] ST_FAIL = 2'h2; // supplies lost, all released

	// counter end values, cut to counter width on purpose
	localparam [31:0] TICK_LAST = TICK_CYCLES - 1;
	localparam [31:0] HOLD_LAST = HOLD_CYCLES - 1;

	// two-flop synchronisers for all pin inputs (17 lines)
	reg  [16:0] meta_q;       // first stage, read only by sync_q
	reg  [16:0] sync_q;       // second stage, safe to use
	reg         recycle_d1_q; // previous synced auto recycle level

	// sequencer state
	reg  [1:0]  state_q;
	reg  [23:0] tick_cnt_q;   // free-running step clock divider
	reg         tick_q;       // one-cycle step pulse
	reg  [2:0]  step_q;       // timing counter within a pass
	reg  [24:0] hold_cnt_q;   // second group energize timer
	reg         hold_run_q;   // timer active
	reg  [10:0] hold_q;       // latched circuits (low-voltage hold)
	reg  [10:0] energize_q;   // high-voltage energize drive
	reg  [3:0]  range_q;      // range of the running or last pass
	reg         screen_off_q;
	reg         busy_q;

	// synced views
	wire        s_auto     = sync_q[0];
	wire [3:0]  s_manual   = sync_q[4:1];
	wire [7:0]  s_thermo   = sync_q[12:5];
	wire        s_recycle  = sync_q[13];
	wire        s_aux_good = sync_q[14];
	wire        s_trip     = sync_q[15];
	wire        s_link_a   = sync_q[16];

	// decoded request and its circuit set
	reg  [3:0]  req_range;
	reg  [10:0] req_mask;
	reg  [10:0] run_mask;     // set of the range now being passed
	reg  [3:0]  ones;
	integer     i;

	// supply failure: aux good low or control trip high
	wire        supply_fail = ~s_aux_good | s_trip;
	// falling edge of the automatic recycle request
	wire        auto_recycle = s_auto & recycle_d1_q & ~s_recycle;
	wire        req_valid    = (req_range != 4'h0);
	// any new range or recycle request starts a pass
	wire        start_req = req_valid &
		((req_range != range_q) | auto_recycle);

	// range set for a circuit pattern; link position A skips stage n-1
	function [10:0] range_mask;
		input [3:0] rng;
		input       link_a;
		integer     n;
		begin
			range_mask = `RSEQ_HOLD_RST;
			case (rng)
				4'h1: range_mask = 11'h003; // stage one a and b
				4'h2: range_mask = 11'h005; // one a, two a
				4'h3: range_mask = 11'h01D; // one a, two a, both three
				default: begin
					if (rng <= 4'h9) begin
						range_mask[`RSEQ_C_TWO_A]   = 1'b1;
						range_mask[`RSEQ_C_THREE_A] = 1'b1;
						range_mask[`RSEQ_C_THREE_B] = 1'b1;
						// stage-A circuits four up to the range
						for (n = 4; n <= 9; n = n + 1) begin
							if (n <= rng)
								range_mask[n + 1] = 1'b1;
						end
						// default links drop stage n-1; range four drops
						// three a, not three b
						if (link_a && rng == 4'h4)
							range_mask[`RSEQ_C_THREE_A] = 1'b0;
						else if (link_a)
							range_mask[rng] = 1'b0;
					end
				end
			endcase
		end
	endfunction

	// range decode: manual switch, or count of thermometer ones
	always @* begin
		ones = 4'h0;
		// thermometer code: each set line adds one range
		for (i = 0; i < 8; i = i + 1)
			ones = ones + {3'h0, s_thermo[i]};
		if (s_auto)
			req_range = ones + 4'h1;
		else if (s_manual <= 4'h9)
			req_range = s_manual; // zero during switch travel: ignored
		else
			req_range = 4'h0;
		req_mask = range_mask(req_range, s_link_a);
		// steps follow the latched range, so switch travel mid-pass
		// cannot pull in a wrong set
		run_mask = range_mask(range_q, s_link_a);
	end

	// input synchronisers
	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_q       <= 17'h00000;
			sync_q       <= 17'h00000;
			recycle_d1_q <= 1'b1;
		end else begin
			meta_q       <= {sequence_option_links_i,
				control_supply_trip_in_i, aux_supplies_good_in_i,
				auto_recycle_n_i, thermo_range_i, manual_range_i,
				auto_mode_i};
			sync_q       <= meta_q;
			recycle_d1_q <= s_recycle;
		end
	end

	// free-running step clock; never reset by the sequence
	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tick_cnt_q <= 24'h000000;
			tick_q     <= 1'b0;
		end else if (tick_cnt_q == TICK_LAST[23:0]) begin
			tick_cnt_q <= 24'h000000;
			tick_q     <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 24'h000001;
			tick_q     <= 1'b0;
		end
	end

	// selection sequencer
	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q      <= ST_FAIL;
			step_q       <= 3'h0;
			hold_cnt_q   <= 25'h0000000;
			hold_run_q   <= 1'b0;
			hold_q       <= `RSEQ_HOLD_RST;
			energize_q   <= `RSEQ_HOLD_RST;
			range_q      <= `RSEQ_RANGE_RST;
			screen_off_q <= 1'b1;
			busy_q       <= 1'b1;
		end else if (supply_fail) begin
			// recycle: drop every circuit and wait
			state_q      <= ST_FAIL;
			hold_q       <= `RSEQ_HOLD_RST;
			energize_q   <= `RSEQ_HOLD_RST;
			hold_run_q   <= 1'b0;
			screen_off_q <= 1'b1;
			busy_q       <= 1'b1;
			range_q      <= `RSEQ_RANGE_RST; // forces a fresh pass
		end else if (start_req) begin
			// supplies back, new range or mid-pass request
			state_q      <= ST_RUN;
			range_q      <= req_range;
			step_q       <= 3'h0;
			screen_off_q <= 1'b1;
			busy_q       <= 1'b1;
			hold_run_q   <= 1'b0;
			// release unneeded circuits; a circuit cut off mid pull-in
			// is released too so the new pass energizes it again
			hold_q       <= hold_q & req_mask & ~energize_q;
			energize_q   <= `RSEQ_HOLD_RST;
		end else begin
			// second group energize timer
			if (hold_run_q) begin
				if (hold_cnt_q == HOLD_LAST[24:0]) begin
					hold_run_q <= 1'b0;
					energize_q <= energize_q & ~`RSEQ_GROUP_SECOND;
				end else begin
					hold_cnt_q <= hold_cnt_q + 25'h0000001;
				end
			end
			case (state_q)
				ST_RUN: begin
					if (tick_q) begin
						step_q <= step_q + 3'h1;
						if (step_q + 3'h1 == `RSEQ_STEP_FIRST) begin
							// first output: latch new group one
							hold_q     <= hold_q | (run_mask &
								`RSEQ_GROUP_FIRST);
							energize_q <= energize_q | (run_mask &
								`RSEQ_GROUP_FIRST & ~hold_q);
						end else if (step_q + 3'h1 == `RSEQ_STEP_SECOND)
						begin
							// second output: group two in, group one to
							// holding only
							hold_q     <= hold_q | (run_mask &
								`RSEQ_GROUP_SECOND);
							energize_q <= (energize_q &
								~`RSEQ_GROUP_FIRST) | (run_mask &
								`RSEQ_GROUP_SECOND & ~hold_q);
							hold_cnt_q <= 25'h0000000;
							hold_run_q <= 1'b1;
						end else if (step_q + 3'h1 == `RSEQ_PASS_STEPS)
						begin
							// pass over after five steps
							state_q      <= ST_IDLE;
							screen_off_q <= 1'b0;
							busy_q       <= 1'b0;
						end
					end
				end
				ST_IDLE: begin
					// settled; requests handled above
					screen_off_q <= 1'b0;
				end
				ST_FAIL: begin
					// supplies good but no valid request yet: stay off
					screen_off_q <= 1'b1;
				end
				default: begin
					state_q <= ST_FAIL;
				end
			endcase
		end
	end

	// outputs straight from flops
	assign coil_hold_o         = hold_q;
	assign coil_energize_o     = energize_q;
	assign screen_supply_off_o = screen_off_q;
	assign selecting_o         = busy_q;
	assign active_range_o      = range_q;

endmodule
`default_nettype wire

// ==== range_seq_defs.vh ====
// constants for the range solenoid sequencer
`ifndef RANGE_SEQ_DEFS_VH
`define RANGE_SEQ_DEFS_VH

// system clock rate in hertz (25 ns period)
`define RSEQ_CLK_HZ          40000000
// free-running step clock period, milliseconds
`define RSEQ_TICK_MS         300
// energize-to-hold delay of the second group after its rise, milliseconds
`define RSEQ_SECOND_HOLD_MS  500
// length of one whole selection pass, milliseconds
`define RSEQ_PASS_MS         1500
// step clock period in system clocks
`define RSEQ_TICK_CYCLES     ((`RSEQ_TICK_MS) * ((`RSEQ_CLK_HZ) / 1000))
// second group delay in system clocks
`define RSEQ_HOLD_CYCLES     ((`RSEQ_SECOND_HOLD_MS) * ((`RSEQ_CLK_HZ) / 1000))
// number of step clocks in one pass
`define RSEQ_PASS_STEPS      3'h5
// step at which the first timing output rises
`define RSEQ_STEP_FIRST      3'h1
// step at which the second timing output rises
`define RSEQ_STEP_SECOND     3'h2

// solenoid circuit bit positions
`define RSEQ_C_ONE_A         0
`define RSEQ_C_ONE_B         1
`define RSEQ_C_TWO_A         2
`define RSEQ_C_THREE_A       3
`define RSEQ_C_THREE_B       4
`define RSEQ_C_FOUR_A        5
`define RSEQ_NUM_CIRCUITS    11

// circuits latched on the first and second timing outputs
`define RSEQ_GROUP_FIRST     11'h7E5
`define RSEQ_GROUP_SECOND    11'h01A

// reset values
`define RSEQ_RANGE_RST       4'h0
`define RSEQ_HOLD_RST        11'h000

`endif

// ==== range_seq_checker.sv ====
// assertion checker for the range solenoid sequencer
`timescale 1ns/10ps
`default_nettype none
`include "range_seq_defs.vh"
module range_seq_checker #(
	parameter integer TICK_CYCLES = 20, // step clock period
	parameter integer HOLD_CYCLES = 30  // second group energize time
) (
	input wire        clk_sys_i,
	input wire        reset_n_i,
	input wire        aux_supplies_good_in_i,
	input wire        control_supply_trip_in_i,
	input wire [10:0] coil_hold_o,
	input wire [10:0] coil_energize_o,
	input wire        screen_supply_off_o,
	input wire        selecting_o,
	input wire [3:0]  active_range_o
);
	reg  [10:0] hold_prev_q;  // hold pattern one cycle back
	reg  [3:0]  range_prev_q; // range one cycle back
	integer     pass_cnt_q;   // cycles spent in the current pass
	integer     g2_cnt_q;     // cycles of second group energizing
	wire [10:0] gained_w  = coil_hold_o & ~hold_prev_q;
	wire [10:0] dropped_w = hold_prev_q & ~coil_hold_o;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	// history and counters; a pass count restarts on any new range
	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hold_prev_q  <= 11'h000;
			range_prev_q <= 4'h0;
			pass_cnt_q   <= 0;
			g2_cnt_q     <= 0;
		end else begin
			hold_prev_q  <= coil_hold_o;
			range_prev_q <= active_range_o;
			pass_cnt_q   <= (!selecting_o ||
				active_range_o != range_prev_q) ? 0 : pass_cnt_q + 1;
			g2_cnt_q     <= ((coil_energize_o & `RSEQ_GROUP_SECOND) != 0) ?
				g2_cnt_q + 1 : 0;
		end
	end
	a_first_energize_ends: assert property (
		(gained_w & `RSEQ_GROUP_SECOND) != 0 |->
		(coil_energize_o & `RSEQ_GROUP_FIRST) == 0)
		else $error("first group still energized at second step");
	a_second_energize_bound: assert property (
		g2_cnt_q <= HOLD_CYCLES + 1)
		else $error("second group energized too long");
	a_groups_staggered: assert property (
		(gained_w & `RSEQ_GROUP_FIRST) == 0 ||
		(gained_w & `RSEQ_GROUP_SECOND) == 0)
		else $error("both groups latched in one cycle");
	a_gain_in_pass: assert property (
		gained_w != 11'h000 |-> selecting_o)
		else $error("circuit latched outside a pass");
	a_drop_at_start: assert property (
		dropped_w != 11'h000 |-> active_range_o != range_prev_q)
		else $error("circuit released without a new cycle");
	a_pass_bound: assert property (
		pass_cnt_q <= 6 * TICK_CYCLES)
		else $error("range pass too long");
	a_fail_clears: assert property (
		!aux_supplies_good_in_i || control_supply_trip_in_i |->
		##[1:4] (coil_hold_o == 11'h000 && active_range_o == 4'h0))
		else $error("supply fault left circuits held");
	a_screen_in_pass: assert property (
		selecting_o |-> screen_supply_off_o)
		else $error("screen supply on during selection");
endmodule
bind range_solenoid_sequencer range_seq_checker #(
	.TICK_CYCLES(TICK_CYCLES),
	.HOLD_CYCLES(HOLD_CYCLES)
) chk_u (
	.clk_sys_i(clk_sys_i),
	.reset_n_i(reset_n_i),
	.aux_supplies_good_in_i(aux_supplies_good_in_i),
	.control_supply_trip_in_i(control_supply_trip_in_i),
	.coil_hold_o(coil_hold_o),
	.coil_energize_o(coil_energize_o),
	.screen_supply_off_o(screen_supply_off_o),
	.selecting_o(selecting_o),
	.active_range_o(active_range_o)
);
`default_nettype wire

// ==== range_source_model.sv ====
// counter module and supply monitor model feeding the sequencer
`timescale 1ns/10ps
`default_nettype none
module range_source_model (
	input  wire logic [3:0] range_i,    // wanted range
	input  wire logic [1:0] fail_i,     // 1 aux lost, 2 control trip
	output logic      [7:0] thermo_o,   // thermometer range code
	output logic            aux_good_o, // high while aux supplies good
	output logic            trip_o      // high when control supply trips
);
	wire [8:0] ones_w = (9'h001 << (range_i - 4'h1)) - 9'h001;
	assign thermo_o   = ones_w[7:0];  // one more line set per range
	assign aux_good_o = ~fail_i[0];
	assign trip_o     = fail_i[1];
endmodule
`default_nettype wire

// ==== range_solenoid_sequencer_tb_top.sv ====
// testbench: every range, random changes, refusal, restart, supply fault
`timescale 1ns/10ps
`default_nettype none
module range_solenoid_sequencer_tb_top;
	reg        clk_sys_i = 1'b0; // 40 MHz system clock
	reg        reset_n_i = 1'b0; // active low reset
	reg        auto_q    = 1'b0; // thermometer source when high
	reg  [3:0] range_q   = 4'h1; // requested range
	reg        rcy_n_q   = 1'b1; // auto recycle strobe
	reg  [1:0] fail_q    = 2'h0; // supply fault kind
	reg        links_q   = 1'b1; // option link position
	reg  [7:0] lfsr_q    = 8'h63;
	wire [7:0]  thermo;
	wire        aux_good, trip, screen_off, selecting;
	wire [10:0] hold, energize;
	wire [3:0]  active;
	integer     err_count = 0;
	integer     tests_run = 0;
	integer     i;
	always #12.5 clk_sys_i = ~clk_sys_i;
	range_source_model src_u (.range_i(range_q), .fail_i(fail_q),
		.thermo_o(thermo), .aux_good_o(aux_good), .trip_o(trip));
	// short step clock keeps a pass near a hundred cycles
	range_solenoid_sequencer #(.TICK_CYCLES(20), .HOLD_CYCLES(30)) dut_u (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.auto_mode_i(auto_q), .manual_range_i(range_q),
		.thermo_range_i(thermo), .auto_recycle_n_i(rcy_n_q),
		.aux_supplies_good_in_i(aux_good),
		.control_supply_trip_in_i(trip),
		.sequence_option_links_i(links_q), .coil_hold_o(hold),
		.coil_energize_o(energize), .screen_supply_off_o(screen_off),
		.selecting_o(selecting), .active_range_o(active));
	function [7:0] lfsr_next(input [7:0] s);
		lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// circuits a settled range must hold
	function [10:0] exp_mask(input [3:0] r, input lk);
		integer k;
		begin
			case (r)
				4'h1: exp_mask = 11'h003;
				4'h2: exp_mask = 11'h005;
				4'h3: exp_mask = 11'h01D;
				default: begin
					exp_mask = 11'h01C;
					for (k = 5; k <= r + 1; k = k + 1)
						exp_mask[k] = 1'b1;
					if (lk)
						exp_mask[(r == 4'h4) ? 3 : r] = 1'b0;
				end
			endcase
		end
	endfunction
	task check(input [10:0] seen, input [10:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
			end
		end
	endtask
	// wait out one pass, then compare the settled outputs
	task settle;
		integer n;
		integer n0;
		begin
			n = 0;
			while (selecting !== 1'b1 && n < 80) begin
				@(negedge clk_sys_i);
				n = n + 1;
			end
			n0 = n;
			while (selecting !== 1'b0 && n < 400) begin
				@(negedge clk_sys_i);
				n = n + 1;
			end
			// five steps of 20 cycles at most, plus input sync slack
			check(n - n0 <= 110, 1'b1);
			check(hold, exp_mask(range_q, links_q));
			check(energize, 11'h000);
			check(active, range_q);
			check(screen_off, 11'h000);
		end
	endtask
	task pick(input rnd);
		begin
			@(negedge clk_sys_i);
			lfsr_q = lfsr_next(lfsr_q);
			auto_q = lfsr_q[0];
			links_q = rnd ? lfsr_q[1] : i[0];
			range_q = rnd ? lfsr_q[7:4] % 9 + 1 : i;
			if (rnd && range_q == active)
				range_q = range_q % 9 + 1;
		end
	endtask
	task test_done;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, err_count);
			if (err_count == 0 && tests_run > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	initial begin
		#500000;
		err_count = err_count + 1;
		test_done;
	end
	initial begin
		repeat (6) @(negedge clk_sys_i);
		reset_n_i = 1'b1;
		for (i = 1; i < 10; i = i + 1) begin
			pick(1'b0);
			settle;
		end
		$display("test all ranges done");
		for (i = 0; i < 8; i = i + 1) begin
			pick(1'b1);
			settle;
		end
		$display("test random ranges done");
		i = range_q;
		auto_q = 1'b0;
		range_q = 4'h0;
		repeat (100) @(negedge clk_sys_i);
		check(selecting, 11'h000);
		check(active, i);
		check(hold, exp_mask(i, links_q));
		pick(1'b1);
		repeat (40) @(negedge clk_sys_i);
		pick(1'b1);
		settle;
		$display("test refusal and restart done");
		for (i = 1; i < 3; i = i + 1) begin
			fail_q = i[1:0];
			repeat (10) @(negedge clk_sys_i);
			check(hold, 11'h000);
			check(active, 4'h0);
			fail_q = 2'h0;
			settle;
		end
		auto_q = 1'b1;
		rcy_n_q = 1'b0;
		repeat (4) @(negedge clk_sys_i);
		rcy_n_q = 1'b1;
		settle;
		$display("test supply fault and recycle done");
		test_done;
	end
endmodule
`default_nettype wire
